// *** storm_limiter.sv ***
// Purpose: per-port storm limiter with APB registers and rx verdicts
// Assumes: one frame descriptor per cycle at most, APB slave with no wait
// Notes:   verdict for a frame appears one cycle after its descriptor
//
// How it works
// R1: three enabled monitors for bc, mc, uc
// R2: percent level in hundredths, zero to hundred
// R3: software keeps falling percent below rising
// R4: software keeps pps falling not above rising
// R5: rising percent of hundred means no limit
// R6: rising pps at all-ones means no limit
// R7: all monitors off after reset
// R8: default action filters, no notification
// R9: no falling level: release below rising
// R10: falling level given: release below it
// R11: mc or uc storm passes only STP
// R12: bc storm drops broadcast only
// R13: shutdown holds port down until re-enabled
// R14: trap raises event, independent of shutdown
// R15: percent relative to current port speed
// R16: count per class per interval, compare
// R17: readable storm-active flag per class
`timescale 1ns/1ps
`default_nettype none
module storm_limiter
  import storm_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = INTERVAL_DEFAULT  // cycles per window
)
(
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_VALID,     // frame descriptor present
  input  wire logic [1:0]  RX_CLASS,     // bc, mc or uc
  input  wire logic [15:0] RX_LEN,       // frame bytes
  input  wire logic        RX_STP,       // spanning-tree frame
  input  wire logic [1:0]  PORT_SPEED,   // 0: 10, 1: 100, 2/3: 1000 Mbps
  output logic             RX_DONE,      // verdict valid
  output logic             RX_DROP,      // drop the frame
  output logic             PORT_UP,      // port enabled
  output logic             STORM_TRAP,   // notification pulse
  output logic      [2:0]  STORM_ACTIVE, // per-class storm flags
  output logic             IRQ
);
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [10:0]       ctrl;            // enables, modes, actions
    logic [3:0]        int_en;          // interrupt enables
    logic [3:0]        int_stat;        // sticky events
    logic [2:0][31:0]  rise;            // rising levels
    logic [2:0][31:0]  fall;            // falling levels
    logic              down;            // port shut down
    logic [31:0]       tick_cnt;        // interval counter
    logic              tick;            // interval end
    logic              done;            // verdict strobe
    logic              drop;            // verdict
    logic              trap;            // notification pulse
    logic [31:0]       prdata;          // read data for access phase
    logic              slverr;          // unmapped access
  } top_state_type;

  top_state_type st_ff;                 // registered state
  top_state_type nxt_st;                // next state
  logic [2:0]    active;                // storm flags from monitors
  logic [2:0]    start;                 // storm start pulses
  logic [10:0]   mbps;                  // current speed
  logic          setup;                 // apb setup phase
  logic          wr;                    // apb write taking effect
  logic          shut_evt;              // storm shuts the port
  logic [3:0]    int_set;               // hardware event bits

  // address decode for the error answer only; read data decodes the address on its own
  function automatic logic addr_ok(input logic [11:0] a);
    logic ok;
    ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_INT_STAT) ||
         (a == ADDR_INT_CLR) || (a == ADDR_INT_EN) || (a == ADDR_REENABLE);
    for (int c = 0; c < NUM_CLS; c++)
    begin
      ok = ok || (a == ADDR_RISE0 + 12'(8 * c)) || (a == ADDR_FALL0 + 12'(8 * c));
    end
    return ok;
  endfunction

  // ******************************
  // class monitors
  // ******************************
  // percentages scale with the speed the port runs at now
  always_comb
  begin
    case (PORT_SPEED)
      2'h0:    mbps = 11'h00a; // R15
      2'h1:    mbps = 11'h064;
      default: mbps = 11'h3e8;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CLS; g++)
    begin : g_mon
      // one independent monitor per class
      storm_monitor #(
        .INTERVAL_CYCLES (INTERVAL_CYCLES)
      ) u_mon (
        .clk        (CLOCK),
        .rstn       (RSTN),
        .tick       (st_ff.tick),
        .hit        (RX_VALID && (RX_CLASS == 2'(g))), // R1
        .len        (RX_LEN),
        .enable     (st_ff.ctrl[CTRL_EN_LSB + g]),
        .pps_mode   (st_ff.ctrl[CTRL_PPS_LSB + g]),
        .fall_valid (st_ff.ctrl[CTRL_FV_LSB + g]),
        .rise       (st_ff.rise[g]),
        .fall       (st_ff.fall[g]),
        .speed_mbps (mbps),
        .active     (active[g]),
        .start      (start[g])
      );
    end
  endgenerate

  // ******************************
  // actions and events
  // ******************************
  // the shutdown event bit only fires when the port was still up
  assign shut_evt = (|start) && st_ff.ctrl[CTRL_SHUT] && !st_ff.down; // R13
  // per-class storm start bits notify only under the trap action
  assign int_set = {shut_evt, start & {3{st_ff.ctrl[CTRL_TRAP]}}}; // R8 R14
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE;

  // next state: counter, verdict, registers, events
  always_comb
  begin
    nxt_st = st_ff;
    // free-running interval counter
    nxt_st.tick = 1'b0;
    nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
    if (st_ff.tick_cnt >= INTERVAL_CYCLES - 1)
    begin
      nxt_st.tick_cnt = 32'h0; // R16
      nxt_st.tick = 1'b1;
    end
    // frame verdict; a down port passes nothing
    nxt_st.done = RX_VALID;
    nxt_st.drop = 1'b0;
    if (RX_VALID)
    begin
      nxt_st.drop = st_ff.down ||
                    ((active[CLS_MC] || active[CLS_UC]) && !RX_STP) || // R11
                    (active[CLS_BC] && (RX_CLASS == CLS_BC)); // R12
    end
    nxt_st.trap = |int_set[2:0]; // R14
    // register writes take effect in the access phase
    if (wr)
    begin
      if (PADDR == ADDR_CTRL)
      begin
        nxt_st.ctrl = PWDATA[10:0]; // R1
      end
      else if (PADDR == ADDR_INT_EN)
      begin
        nxt_st.int_en = PWDATA[3:0];
      end
      else if (PADDR == ADDR_INT_CLR)
      begin
        nxt_st.int_stat = st_ff.int_stat & ~PWDATA[3:0];
      end
      else if (PADDR == ADDR_REENABLE)
      begin
        // management brings the port back explicitly
        if (PWDATA[0])
        begin
          nxt_st.down = 1'b0; // R13
        end
      end
      else
      begin
        for (int c = 0; c < NUM_CLS; c++)
        begin
          if (PADDR == ADDR_RISE0 + 12'(8 * c))
          begin
            nxt_st.rise[c] = PWDATA; // R2 R4
          end
          if (PADDR == ADDR_FALL0 + 12'(8 * c))
          begin
            nxt_st.fall[c] = PWDATA; // R3 R4
          end
        end
      end
    end
    // hardware sets win over software clears
    nxt_st.int_stat = nxt_st.int_stat | int_set;
    // a storm start keeps the port down even against a re-enable write
    if ((|start) && st_ff.ctrl[CTRL_SHUT])
    begin
      nxt_st.down = 1'b1; // R13
    end
    // read data is latched in setup so it stands through access
    nxt_st.prdata = 32'h0;
    nxt_st.slverr = 1'b0;
    if (setup)
    begin
      nxt_st.slverr = !addr_ok(PADDR);
      if (PADDR == ADDR_CTRL)
      begin
        nxt_st.prdata = 32'(st_ff.ctrl);
      end
      else if (PADDR == ADDR_STATUS)
      begin
        nxt_st.prdata = 32'({PORT_SPEED, st_ff.down, active}); // R17
      end
      else if (PADDR == ADDR_INT_STAT)
      begin
        nxt_st.prdata = 32'(st_ff.int_stat);
      end
      else if (PADDR == ADDR_INT_EN)
      begin
        nxt_st.prdata = 32'(st_ff.int_en);
      end
      else
      begin
        for (int c = 0; c < NUM_CLS; c++)
        begin
          if (PADDR == ADDR_RISE0 + 12'(8 * c))
          begin
            nxt_st.prdata = st_ff.rise[c];
          end
          if (PADDR == ADDR_FALL0 + 12'(8 * c))
          begin
            nxt_st.prdata = st_ff.fall[c];
          end
        end
      end
    end
  end

  // register, synchronous active-low reset
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      st_ff <= '{ctrl: CTRL_RST, int_en: INT_RST, int_stat: INT_RST,
                 rise: {3{LEVEL_RST}}, fall: {3{LEVEL_RST}}, default: '0}; // R7
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign PRDATA = st_ff.prdata;
  assign PREADY = 1'b1;                 // zero-wait slave
  assign PSLVERR = st_ff.slverr && PSEL && PENABLE;
  assign RX_DONE = st_ff.done;
  assign RX_DROP = st_ff.drop;
  assign PORT_UP = !st_ff.down;
  assign STORM_TRAP = st_ff.trap;
  assign STORM_ACTIVE = active;
  assign IRQ = |(st_ff.int_stat & st_ff.int_en);

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  chk_reset_off: assert property ($rose(RSTN) |-> st_ff.ctrl == CTRL_RST) // R7
    else $error("monitors enabled straight after reset");
  chk_mcuc_filter: assert property (RX_VALID && !RX_STP && (active[CLS_MC] || active[CLS_UC])
                                    |=> RX_DONE && RX_DROP) // R11
    else $error("frame passed during mc or uc storm");
  chk_stp_pass: assert property (RX_VALID && RX_STP && !st_ff.down && !active[CLS_BC]
                                 |=> !RX_DROP) // R11
    else $error("spanning-tree frame dropped");
  chk_bc_only: assert property (RX_VALID && RX_CLASS != CLS_BC && active == 3'b001
                                && !st_ff.down |=> !RX_DROP) // R12
    else $error("non-broadcast frame dropped in broadcast storm");
  chk_shut_down: assert property ((|start) && st_ff.ctrl[CTRL_SHUT] |=> !PORT_UP) // R13
    else $error("port stayed up after storm with shutdown");
  chk_stay_down: assert property (!PORT_UP && !(wr && PADDR == ADDR_REENABLE && PWDATA[0])
                                  |=> !PORT_UP) // R13
    else $error("port came up without re-enable");
  chk_trap_pulse: assert property ((|start) && st_ff.ctrl[CTRL_TRAP] |=> STORM_TRAP ##1 !STORM_TRAP) // R14
    else $error("trap not raised as one pulse");
  chk_no_trap: assert property (!st_ff.ctrl[CTRL_TRAP] |=> !STORM_TRAP) // R8
    else $error("notification without trap action");
  chk_tick_gap: assert property (st_ff.tick |=> !st_ff.tick) // R16
    else $error("interval end repeated");
endmodule
`default_nettype wire

// *** storm_pkg.sv ***
// Purpose: shared constants for the per-port storm limiter
// Assumes: 250 MHz switch clock, APB register access, 32-bit data
// Notes:   register offsets are byte addresses; classes index the monitors
package storm_pkg;
  // ******************************
  // clock and measurement interval
  // ******************************
  localparam int unsigned CLOCK_MHZ        = 250;          // switch clock rate
  localparam int unsigned CLOCK_HZ         = 250000000;
  localparam int unsigned INTERVAL_US      = 1000;         // measurement window in us
  localparam int unsigned INTERVAL_DEFAULT = INTERVAL_US * CLOCK_MHZ;
  // ******************************
  // traffic classes and limits
  // ******************************
  localparam logic [1:0]  CLS_BC      = 2'h0;              // broadcast monitor
  localparam logic [1:0]  CLS_MC      = 2'h1;              // multicast monitor
  localparam logic [1:0]  CLS_UC      = 2'h2;              // unicast monitor
  localparam int unsigned NUM_CLS     = 3;
  localparam logic [31:0] PCT_NOLIMIT = 32'h0000_2710;     // 100.00 percent in hundredths
  localparam logic [31:0] PPS_NOLIMIT = 32'hffff_ffff;     // top of packet-rate range
  localparam logic [63:0] PCT_SCALE   = 64'h0000_0000_0131_2d00; // 8 bits * MHz * 10000
  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_INT_STAT = 12'h008;
  localparam logic [11:0] ADDR_INT_CLR  = 12'h00c;
  localparam logic [11:0] ADDR_INT_EN   = 12'h010;
  localparam logic [11:0] ADDR_REENABLE = 12'h014;
  localparam logic [11:0] ADDR_RISE0    = 12'h020;        // rise of class c at 0x20 + 8c
  localparam logic [11:0] ADDR_FALL0    = 12'h024;        // fall of class c at 0x24 + 8c
  // control field positions
  localparam int unsigned CTRL_EN_LSB   = 0;              // [2:0] monitor enables
  localparam int unsigned CTRL_PPS_LSB  = 3;              // [5:3] packet-rate mode
  localparam int unsigned CTRL_FV_LSB   = 6;              // [8:6] falling level valid
  localparam int unsigned CTRL_SHUT     = 9;              // shutdown action
  localparam int unsigned CTRL_TRAP     = 10;             // trap action
  // interrupt bits: [2:0] storm start per class, [3] port shut down
  localparam int unsigned INT_SHUT      = 3;
  // reset values
  localparam logic [10:0] CTRL_RST      = 11'h000;
  localparam logic [31:0] LEVEL_RST     = 32'h0000_0000;
  localparam logic [3:0]  INT_RST       = 4'h0;
endpackage

// *** storm_monitor.sv ***
// Purpose: one traffic-class storm monitor with hysteresis
// Assumes: tick marks the first cycle of each measurement interval and closes the one before
// Notes:   counts every received frame of its class, dropped or not
`timescale 1ns/1ps
`default_nettype none
module storm_monitor
  import storm_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = INTERVAL_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        tick,        // interval end
  input  wire logic        hit,         // frame of this class
  input  wire logic [15:0] len,         // frame length in bytes
  input  wire logic        enable,
  input  wire logic        pps_mode,    // 1: packets per second, 0: percent
  input  wire logic        fall_valid,
  input  wire logic [31:0] rise,
  input  wire logic [31:0] fall,
  input  wire logic [10:0] speed_mbps,
  output logic             active,      // storm flag
  output logic             start        // one-cycle pulse when a storm begins
);
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [31:0] bytes;                 // bytes seen in this interval
    logic [31:0] pkts;                  // frames seen in this interval
    logic        active;
    logic        start;
  } mon_state_type;

  mon_state_type st_ff;                 // registered state
  mon_state_type nxt_st;                // next state
  logic          limited;               // limit is in force
  logic          rise_hit;              // measured rate at or above rise
  logic          below_rel;             // measured rate below release level
  logic [31:0]   rel;                   // release level

  // true when the interval's rate is at or above thr
  function automatic logic reached(input logic [31:0] b, input logic [31:0] p,
                                   input logic [31:0] thr, input logic pps,
                                   input logic [10:0] mbps);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(b) * PCT_SCALE;
    rhs = 64'(mbps) * 64'(INTERVAL_CYCLES) * 64'(thr);
    if (pps)
    begin
      // wide products avoid dividing down to a per-second count
      lhs = 64'(p) * 64'(CLOCK_HZ);
      rhs = 64'(thr) * 64'(INTERVAL_CYCLES);
    end
    return lhs >= rhs;
  endfunction

  // ******************************
  // interval measurement and flag
  // ******************************
  // rise at the top of its range means no limit at all
  assign limited = enable & (pps_mode ? (rise != PPS_NOLIMIT) : (rise < PCT_NOLIMIT)); // R5 R6
  assign rel = fall_valid ? fall : rise; // R9 R10
  assign rise_hit = reached(st_ff.bytes, st_ff.pkts, rise, pps_mode, speed_mbps); // R2 R15
  assign below_rel = !reached(st_ff.bytes, st_ff.pkts, rel, pps_mode, speed_mbps);

  // counting and end-of-interval compare
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    if (tick)
    begin
      // a frame in the tick cycle opens the next interval
      nxt_st.bytes = hit ? 32'(len) : 32'h0; // R16
      nxt_st.pkts = hit ? 32'h1 : 32'h0;
      if (!limited)
      begin
        nxt_st.active = 1'b0;
      end
      else if (!st_ff.active && rise_hit)
      begin
        nxt_st.active = 1'b1; // R17
        nxt_st.start = 1'b1;
      end
      else if (st_ff.active && below_rel)
      begin
        nxt_st.active = 1'b0; // R9 R10
      end
    end
    else if (hit)
    begin
      nxt_st.bytes = st_ff.bytes + 32'(len); // R16
      nxt_st.pkts = st_ff.pkts + 32'h1;
    end
  end

  // register, synchronous active-low reset; monitor starts idle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_ff <= '0; // R7
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign active = st_ff.active;
  assign start = st_ff.start;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_nolimit_idle: assert property (tick && !limited |=> !active) // R5
    else $error("storm flag set without a limit in force");
  chk_hold_between: assert property (!tick && !start |=> active == $past(active)) // R16
    else $error("storm flag moved between interval ends");
  chk_fall_hold: assert property (tick && active && fall_valid && limited
                                  && !below_rel |=> active) // R10
    else $error("storm released above falling level");
  chk_rise_release: assert property (tick && active && !fall_valid && below_rel |=> !active) // R9
    else $error("storm not released below rising level");
endmodule
`default_nettype wire

// *** rx_source.sv ***
// Purpose: receive-path model that hands frame descriptors to the limiter
// Assumes: send is called just after a rising edge, one frame per call
// Notes:   released fields show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module rx_source
(
  input  wire logic        clk,    // switch clock
  output logic             valid,  // descriptor present
  output logic      [1:0]  cls,    // traffic class
  output logic      [15:0] len,    // frame bytes
  output logic             stp     // spanning-tree frame
);
  // idle at time zero; class 3 is counted by no monitor
  initial
  begin
    valid = 1'b0;
    cls   = 2'h3;
    len   = 16'h0000;
    stp   = 1'b0;
  end

  // one-cycle descriptor; stale fields are scrambled so nothing leans on them
  task automatic send(input logic [1:0] c, input logic [15:0] l, input logic s);
    valid <= 1'b1;
    cls   <= c;
    len   <= l;
    stp   <= s;
    @(posedge clk);
    valid <= 1'b0;
    cls   <= ~c;
    len   <= ~l;
    stp   <= ~s;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the storm limiter
// Assumes: short 1000-cycle window, so one frame is 250000 packets per second
// Notes:   verdicts and read data are checked from expectation queues
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import storm_pkg::*;
  // ******************************
  // signals and bookkeeping
  // ******************************
  logic        clk, rstn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rx_valid, rx_stp, rx_done, rx_drop, port_up, trap, irq;
  logic [1:0]  rx_class, speed;
  logic [15:0] rx_len;
  logic [2:0]  active;
  logic [32:0] rexp_q[$];   // read notes: {error, data}
  logic [1:0]  exp_q[$];    // verdict notes: {care, drop}
  logic [32:0] rexp;
  logic [1:0]  x;
  int          error_cnt, comparisons, trap_cnt;
  int          seed = 43404;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  storm_limiter #(.INTERVAL_CYCLES(1000)) u_dut (
    .CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_CLASS(rx_class), .RX_LEN(rx_len),
    .RX_STP(rx_stp), .PORT_SPEED(speed), .RX_DONE(rx_done), .RX_DROP(rx_drop),
    .PORT_UP(port_up), .STORM_TRAP(trap), .STORM_ACTIVE(active), .IRQ(irq));

  rx_source u_src (.clk(clk), .valid(rx_valid), .cls(rx_class), .len(rx_len), .stp(rx_stp));

  // ******************************
  // comparison and closing
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // read data is taken at the rising edge that samples pready high
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      rexp = rexp_q.pop_front();
      check(prdata, rexp[31:0]);
      check({31'h0, pslverr}, {31'h0, rexp[32]});
    end
  end

  // rx verdicts are looked at mid-cycle, where registered values have settled
  always @(negedge clk)
  begin
    if (trap === 1'b1)
      trap_cnt++;
    if (rx_done === 1'b1)
    begin
      // a verdict with no frame behind it is a mismatch
      if (exp_q.size() == 0)
        check({31'h0, rx_done}, 32'h0);
      else
      begin
        x = exp_q.pop_front();
        if (x[1])
          check({31'h0, rx_drop}, {31'h0, x[0]});
      end
    end
  end

  // ******************************
  // bus and traffic tasks
  // ******************************
  // apb transfer; request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      error_cnt++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rexp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  // management keeps falling at or below rising in every call
  task automatic lvl(input logic [1:0] c, input logic [31:0] r, input logic [31:0] f);
    wr(ADDR_RISE0 + 12'({c, 3'h0}), r);
    wr(ADDR_FALL0 + 12'({c, 3'h0}), f);
  endtask

  // n frames, one every gap cycles; len 0 asks for a random length
  task automatic traffic(input logic [1:0] c, input logic s, input int gap, input int n,
                         input logic [15:0] len, input logic care, input logic e);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back({care, e});
      u_src.send(c, (len == 0) ? 16'(64 + ($random(seed) & 1023)) : len, s);
      repeat (gap - 1) @(posedge clk);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // bound on the whole run
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    speed = 2'h2;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // reset state, refusals, disabled monitors with zero levels
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_STATUS, 32'h20, 1'b0);
    rd(ADDR_RISE0, 32'h0, 1'b0);
    wr(ADDR_INT_STAT, 32'hf);
    rd(ADDR_INT_STAT, 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    traffic(CLS_BC, 1'b0, 20, 150, 16'h0, 1'b1, 1'b0);
    done("reset");
    // broadcast storm filters broadcast only, silently
    lvl(CLS_BC, 32'd2500000, 32'd0);
    wr(ADDR_CTRL, 32'h009);
    traffic(CLS_BC, 1'b0, 50, 60, 16'h0, 1'b0, 1'b0);
    rd(ADDR_STATUS, 32'h21, 1'b0);
    repeat (10)
    begin
      traffic(CLS_BC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b1);
      traffic(CLS_MC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b0);
      traffic(CLS_UC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b0);
    end
    rd(ADDR_INT_STAT, 32'h0, 1'b0);
    @(negedge clk);
    check(32'(trap_cnt), 32'd0);
    check({31'h0, port_up}, 32'h1);
    @(posedge clk);
    done("broadcast");
    // between the levels: held with a falling level, released without
    wr(ADDR_CTRL, 32'h049);
    lvl(CLS_BC, 32'd2500000, 32'd500000);
    traffic(CLS_BC, 1'b0, 200, 20, 16'h0, 1'b0, 1'b0);
    @(negedge clk);
    check({29'h0, active}, 32'h1);
    @(posedge clk);
    wr(ADDR_CTRL, 32'h009);
    traffic(CLS_BC, 1'b0, 200, 15, 16'h0, 1'b0, 1'b0);
    @(negedge clk);
    check({29'h0, active}, 32'h0);
    @(posedge clk);
    done("hysteresis");
    // multicast storm with trap: only spanning-tree frames pass
    lvl(CLS_MC, 32'd2500000, 32'd0);
    wr(ADDR_INT_EN, 32'hf);
    wr(ADDR_CTRL, 32'h412);
    traffic(CLS_MC, 1'b0, 50, 60, 16'h0, 1'b0, 1'b0);
    repeat (10)
    begin
      traffic(CLS_MC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b1);
      traffic(CLS_BC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b1);
      traffic(CLS_UC, 1'b1, 20, 1, 16'h0, 1'b1, 1'b0);
    end
    rd(ADDR_INT_STAT, 32'h2, 1'b0);
    @(negedge clk);
    check(32'(trap_cnt), 32'd1);
    check({30'h0, port_up, irq}, 32'h3);
    @(posedge clk);
    wr(ADDR_INT_EN, 32'h0);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    @(posedge clk);
    wr(ADDR_INT_EN, 32'hf);
    wr(ADDR_INT_CLR, 32'h2);
    rd(ADDR_INT_STAT, 32'h0, 1'b0);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    @(posedge clk);
    done("trap");
    // unicast storm with shutdown: port stays down until re-enabled
    lvl(CLS_UC, 32'd2500000, 32'd0);
    wr(ADDR_CTRL, 32'h224);
    traffic(CLS_UC, 1'b0, 50, 60, 16'h0, 1'b0, 1'b0);
    rd(ADDR_INT_STAT, 32'h8, 1'b0);
    repeat (2500) @(posedge clk);
    @(negedge clk);
    check({28'h0, port_up, active}, 32'h0);
    @(posedge clk);
    traffic(CLS_BC, 1'b1, 20, 1, 16'h0, 1'b1, 1'b1);
    wr(ADDR_REENABLE, 32'h1);
    traffic(CLS_BC, 1'b0, 20, 1, 16'h0, 1'b1, 1'b0);
    wr(ADDR_INT_CLR, 32'h8);
    done("shutdown");
    // no-limit levels in both modes, then percent against port speed
    lvl(CLS_BC, PPS_NOLIMIT, 32'd0);
    lvl(CLS_MC, PPS_NOLIMIT, 32'd0);
    lvl(CLS_UC, PPS_NOLIMIT, 32'd0);
    wr(ADDR_CTRL, 32'h03f);
    repeat (50)
      for (int c = 0; c < 3; c++)
        traffic(2'(c), 1'b0, 20, 1, 16'h0, 1'b1, 1'b0);
    wr(ADDR_CTRL, 32'h004);
    speed <= 2'h0;
    lvl(CLS_UC, PCT_NOLIMIT, 32'd0);
    // 20 bytes a window: 40 Mbps, above 10 percent of 10 and 100, below 1000
    traffic(CLS_UC, 1'b0, 500, 8, 16'd10, 1'b1, 1'b0);
    lvl(CLS_UC, 32'd1000, 32'd0);
    traffic(CLS_UC, 1'b0, 500, 8, 16'd10, 1'b0, 1'b0);
    @(negedge clk);
    check({29'h0, active}, 32'h4);
    @(posedge clk);
    speed <= 2'h2;
    traffic(CLS_UC, 1'b0, 500, 8, 16'd10, 1'b0, 1'b0);
    @(negedge clk);
    check({29'h0, active}, 32'h0);
    @(posedge clk);
    speed <= 2'h1;
    traffic(CLS_UC, 1'b0, 500, 8, 16'd10, 1'b0, 1'b0);
    @(negedge clk);
    check({29'h0, active}, 32'h4);
    @(posedge clk);
    done("levels");
    print_verdict();
  end
endmodule
`default_nettype wire
